// File: hw/sotp_pkg.sv
package sotp_pkg;
  localparam int ADDR_W = 13;
  localparam int ROW_W  = 13;
  localparam int COL_W  = 9;
  localparam int DATA_W = 32;
  localparam int LAT_MAX = 6;

  localparam logic [1:0] MRS_LOCK_CYC = 2'h3;

  localparam int MF_LAT_HI = 5;
  localparam int MF_LAT_LO = 3;
  localparam int MF_ILV    = 2;
  localparam int MF_BL_HI  = 1;
  localparam int MF_BL_LO  = 0;
  localparam logic [2:0] LAT_CODE_4 = 3'h3;
  localparam logic [2:0] LAT_CODE_6 = 3'h5;
  localparam logic [2:0] LAT_CODE_OFS = 3'h1;
  localparam logic [1:0] BL_CODE_4 = 2'h1;
  localparam logic [1:0] BL_CODE_8 = 2'h2;
  localparam logic [2:0] BL4_MASK = 3'h3;
  localparam logic [2:0] BL8_MASK = 3'h7;
  localparam logic [2:0] TAP_OFS  = 3'h2;

  localparam logic [2:0] RST_LAT = 3'h5;
  localparam logic       RST_ILV = 1'h0;
  localparam logic       RST_BL8 = 1'h0;

  localparam logic [31:0] REG_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] REG_STAT_ADDR = 32'h0000_0004;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RST   = 1'h1;
  localparam int ST_STATE_LO = 0;
  localparam int ST_LAT_LO   = 4;
  localparam int ST_ILV_BIT  = 7;
  localparam int ST_BL8_BIT  = 8;
  localparam int ST_WIDE_BIT = 9;
  localparam int ST_LOCK_BIT = 10;
  localparam int ST_ROW_LO   = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_READ    = 2'b01,
    ST_SUSPEND = 2'b10,
    ST_PDOWN   = 2'b11
  } sotp_state_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_MRS = 3'b001,
    CMD_ACT = 3'b010,
    CMD_RD  = 3'b011,
    CMD_BST = 3'b100,
    CMD_PRE = 3'b101
  } sotp_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic mw_n;
  } sotp_pins_t;

  typedef struct packed {
    logic [2:0] lat;
    logic       ilv;
    logic       bl8;
  } sotp_mode_t;

  typedef struct packed {
    logic             wide;
    logic [COL_W-1:0] col;
  } sotp_beat_t;
endpackage : sotp_pkg

// File: hw/sotp_cmd_dec.sv
`timescale 1ns/100ps
module sotp_cmd_dec (
  input  wire sotp_pkg::sotp_pins_t pins,
  input  wire logic      enable,
  output sotp_pkg::sotp_cmd_t cmd
);
  import sotp_pkg::*;

  always_comb begin
    cmd = CMD_NOP;
    if (enable && !pins.cs_n) begin
      case ({pins.ras_n, pins.cas_n, pins.mw_n})
        3'b000:  cmd = CMD_MRS;
        3'b011:  cmd = CMD_ACT;
        3'b101:  cmd = CMD_RD;
        3'b110:  cmd = CMD_BST;
        3'b010:  cmd = CMD_PRE;
        default: cmd = CMD_NOP;
      endcase
    end
  end
endmodule : sotp_cmd_dec

// File: hw/sotp_lat_pipe.sv
`timescale 1ns/100ps
module sotp_lat_pipe #(
  parameter int DEPTH = 5,
  parameter int W     = 10,
  parameter int TAP_W = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             adv,
  input  wire logic             in_vld,
  input  wire logic [W-1:0]     in_data,
  input  wire logic [TAP_W-1:0] tap_sel,
  output logic                  out_vld,
  output logic [W-1:0]          out_data,
  output logic                  busy
);
  logic [DEPTH-1:0] vld_ff;
  logic [W-1:0]     data_ff [DEPTH];

  if (DEPTH < 2 || (1 << TAP_W) < DEPTH) begin : g_bad
    $error("sotp_lat_pipe: bad DEPTH or TAP_W");
  end

  // Frozen while adv is low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vld_ff <= '0;
    end else if (adv) begin
      vld_ff <= {vld_ff[DEPTH-2:0], in_vld};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (adv) begin
      data_ff[0] <= in_data;
      for (int i = 1; i < DEPTH; i++) begin
        data_ff[i] <= data_ff[i-1];
      end
    end
  end

  always_comb begin
    out_vld  = 1'b0;
    out_data = '0;
    busy     = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (i <= int'(tap_sel)) begin
        busy = busy | vld_ff[i];
      end
      if (i == int'(tap_sel)) begin
        out_vld  = vld_ff[i];
        out_data = data_ff[i];
      end
    end
  end
endmodule : sotp_lat_pipe

// File: hw/sotp_read_ctrl.sv
`timescale 1ns/100ps
module sotp_read_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  // Command pins
  input  wire logic                        clk_gate_in,
  input  wire logic                        chip_select_n,
  input  wire logic                        row_strobe_n,
  input  wire logic                        col_strobe_n,
  input  wire logic                        mode_write_n,
  input  wire logic                        width_select,
  input  wire logic                        output_mask,
  input  wire logic                        static_op_select,
  input  wire logic [sotp_pkg::ADDR_W-1:0] addr_in,
  // Array port
  output logic                             array_rd,
  output logic [sotp_pkg::ROW_W-1:0]       array_row,
  output logic [sotp_pkg::COL_W-1:0]       array_col,
  output logic                             array_wide,
  input  wire logic [sotp_pkg::DATA_W-1:0] array_rdata,
  // Data pins
  output logic [sotp_pkg::DATA_W-1:0]      dq_out,
  output logic                             dq_oe
);
  import sotp_pkg::*;

  localparam int PIPE_D = LAT_MAX - 1;
  localparam int BEAT_W = $bits(sotp_beat_t);

  sotp_state_t      state_ff;
  sotp_state_t      nxt_state;
  sotp_mode_t       mode_ff;
  sotp_cmd_t        cmd;
  sotp_pins_t       pins;
  sotp_beat_t       beat;
  sotp_beat_t       tap_beat;
  logic             cke_prev_ff;
  logic [1:0]       lock_cnt_ff;
  logic [ROW_W-1:0] row_address_in_ff;
  logic             issue_act_ff;
  logic [2:0]       beat_cnt_ff;
  logic [COL_W-1:0] start_col_ff;
  logic             wide_ff;
  logic             last_wide_ff;
  logic             port_en_ff;
  logic             run;
  logic             cmd_ok;
  logic             beat_vld;
  logic             tap_vld;
  logic             pipe_busy;
  logic             stop_issue;
  logic [2:0]       bl_last;
  logic [2:0]       tap_sel;
  logic [DATA_W-1:0] dq_out_ff;
  logic             dq_vld_ff;
  logic             ahb_act_ff;
  logic             ahb_wr_ff;
  logic [31:0]      ahb_addr_ff;
  logic [31:0]      hrdata_ff;
  logic [31:0]      stat_word;

  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] start,
    input logic [2:0]       k,
    input sotp_mode_t       m
  );
    logic [2:0] msk;
    logic [2:0] low;
    msk = m.bl8 ? BL8_MASK : BL4_MASK;
    low = m.ilv ? (start[2:0] ^ k) : 3'(start[2:0] + k);
    burst_col = {start[COL_W-1:3], (start[2:0] & ~msk) | (low & msk)};
  endfunction : burst_col

  // Command decode gating
  assign pins = '{cs_n: chip_select_n, ras_n: row_strobe_n,
                  cas_n: col_strobe_n, mw_n: mode_write_n};

  always_comb begin
    cmd_ok = cke_prev_ff && !static_op_select && port_en_ff;
    if (lock_cnt_ff != 2'h0) begin
      cmd_ok = 1'b0;
    end
    case (state_ff)
      ST_STANDBY: cmd_ok = cmd_ok;
      ST_READ:    cmd_ok = cmd_ok && clk_gate_in;
      default:    cmd_ok = 1'b0;
    endcase
  end

  sotp_cmd_dec u_dec (
    .pins   (pins),
    .enable (cmd_ok),
    .cmd    (cmd)
  );

  // Clock enable sampled one cycle back
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cke_prev_ff <= 1'b1;
    end else begin
      cke_prev_ff <= clk_gate_in;
    end
  end

  // Mode set lockout
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_ff <= 2'h0;
    end else if (cmd == CMD_MRS && state_ff == ST_STANDBY) begin
      lock_cnt_ff <= MRS_LOCK_CYC;
    end else if (lock_cnt_ff != 2'h0) begin
      lock_cnt_ff <= lock_cnt_ff - 2'h1;
    end
  end

  // Mode register; reserved codes leave a field unchanged
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= '{lat: RST_LAT, ilv: RST_ILV, bl8: RST_BL8};
    end else if (cmd == CMD_MRS && state_ff == ST_STANDBY) begin
      if (addr_in[MF_LAT_HI:MF_LAT_LO] >= LAT_CODE_4 &&
          addr_in[MF_LAT_HI:MF_LAT_LO] <= LAT_CODE_6) begin
        mode_ff.lat <= addr_in[MF_LAT_HI:MF_LAT_LO] + LAT_CODE_OFS;
      end
      mode_ff.ilv <= addr_in[MF_ILV];
      if (addr_in[MF_BL_HI:MF_BL_LO] == BL_CODE_4) begin
        mode_ff.bl8 <= 1'b0;
      end else if (addr_in[MF_BL_HI:MF_BL_LO] == BL_CODE_8) begin
        mode_ff.bl8 <= 1'b1;
      end
    end
  end

  // Row latch kept through suspend and power down
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      row_address_in_ff <= '0;
    end else if (cmd == CMD_ACT) begin
      row_address_in_ff <= addr_in[ROW_W-1:0];
    end
  end

  // Burst issue
  assign run        = (state_ff != ST_SUSPEND);
  assign bl_last    = mode_ff.bl8 ? BL8_MASK : BL4_MASK;
  assign stop_issue = (cmd == CMD_BST) || (cmd == CMD_PRE) || (cmd == CMD_ACT);

  always_comb begin
    beat_vld = 1'b0;
    beat     = '{wide: wide_ff, col: burst_col(start_col_ff, beat_cnt_ff, mode_ff)};
    if (cmd == CMD_RD) begin
      beat_vld = 1'b1;
      beat     = '{wide: width_select, col: addr_in[COL_W-1:0]};
    end else if (issue_act_ff && run && !stop_issue) begin
      beat_vld = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      issue_act_ff <= 1'b0;
      beat_cnt_ff  <= 3'h0;
      start_col_ff <= '0;
      wide_ff      <= 1'b0;
    end else if (cmd == CMD_RD) begin
      issue_act_ff <= 1'b1;
      beat_cnt_ff  <= 3'h1;
      start_col_ff <= addr_in[COL_W-1:0];
      wide_ff      <= width_select;
    end else if (stop_issue) begin
      issue_act_ff <= 1'b0;
    end else if (beat_vld) begin
      beat_cnt_ff <= 3'(beat_cnt_ff + 3'h1);
      if (beat_cnt_ff == bl_last) begin
        issue_act_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_wide_ff <= 1'b0;
    end else if (cmd == CMD_RD) begin
      last_wide_ff <= width_select;
    end
  end

  // Read latency pipeline
  assign tap_sel = mode_ff.lat - TAP_OFS;

  sotp_lat_pipe #(
    .DEPTH (PIPE_D),
    .W     (BEAT_W),
    .TAP_W (3)
  ) u_pipe (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .adv      (run),
    .in_vld   (beat_vld),
    .in_data  (beat),
    .tap_sel  (tap_sel),
    .out_vld  (tap_vld),
    .out_data (tap_beat),
    .busy     (pipe_busy)
  );

  assign array_rd   = tap_vld && run;
  assign array_row  = row_address_in_ff;
  assign array_col  = tap_beat.col;
  assign array_wide = tap_beat.wide;

  // Output data register, frozen in suspend
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dq_out_ff <= '0;
      dq_vld_ff <= 1'b0;
    end else if (run) begin
      dq_vld_ff <= tap_vld;
      if (tap_vld) begin
        dq_out_ff <= array_rdata;
      end
    end
  end

  assign dq_out = dq_out_ff;
  assign dq_oe  = dq_vld_ff && !output_mask;

  // Operating state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY: begin
        if (cmd == CMD_RD) begin
          nxt_state = ST_READ;
        end else if (!clk_gate_in && chip_select_n) begin
          nxt_state = ST_PDOWN;
        end
      end
      ST_READ: begin
        if (!issue_act_ff && !pipe_busy && cmd != CMD_RD) begin
          nxt_state = ST_STANDBY;
        end else if (!clk_gate_in) begin
          nxt_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (clk_gate_in) begin
          nxt_state = ST_READ;
        end
      end
      ST_PDOWN: begin
        if (clk_gate_in) begin
          nxt_state = ST_STANDBY;
        end
      end
      default: nxt_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // AHB-Lite register slave, zero wait states
  always_comb begin
    stat_word = '0;
    stat_word[ST_STATE_LO +: 2]  = state_ff;
    stat_word[ST_LAT_LO +: 3]    = mode_ff.lat;
    stat_word[ST_ILV_BIT]        = mode_ff.ilv;
    stat_word[ST_BL8_BIT]        = mode_ff.bl8;
    stat_word[ST_WIDE_BIT]       = last_wide_ff;
    stat_word[ST_LOCK_BIT]       = (lock_cnt_ff != 2'h0);
    stat_word[ST_ROW_LO +: ROW_W] = row_address_in_ff;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ahb_act_ff  <= 1'b0;
      ahb_wr_ff   <= 1'b0;
      ahb_addr_ff <= '0;
      hrdata_ff   <= '0;
    end else if (hready) begin
      ahb_act_ff  <= hsel && (htrans == HTRANS_NONSEQ);
      ahb_wr_ff   <= hwrite;
      ahb_addr_ff <= haddr;
      if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        if (haddr == REG_CTRL_ADDR) begin
          hrdata_ff <= {31'h0000_0000, port_en_ff};
        end else if (haddr == REG_STAT_ADDR) begin
          hrdata_ff <= stat_word;
        end else begin
          hrdata_ff <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      port_en_ff <= CTRL_EN_RST;
    end else if (ahb_act_ff && ahb_wr_ff && ahb_addr_ff == REG_CTRL_ADDR) begin
      port_en_ff <= hwdata[CTRL_EN_BIT];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_ff;
endmodule : sotp_read_ctrl

// File: verif/sotp_read_ctrl_properties.sv
`timescale 1ns/100ps
module sotp_read_ctrl_properties (
  input wire logic                        clk_sys,
  input wire logic                        rstn,
  input wire logic                        clk_gate_in,
  input wire logic                        chip_select_n,
  input wire logic                        row_strobe_n,
  input wire logic                        col_strobe_n,
  input wire logic                        mode_write_n,
  input wire logic                        width_select,
  input wire logic                        output_mask,
  input wire logic                        static_op_select,
  input wire logic [sotp_pkg::ADDR_W-1:0] addr_in,
  input wire logic                        array_rd,
  input wire logic [sotp_pkg::ROW_W-1:0]  array_row,
  input wire logic                        array_wide,
  input wire logic [sotp_pkg::DATA_W-1:0] dq_out,
  input wire logic                        dq_oe
);
  import sotp_pkg::*;
  logic       gate_q_ff;
  logic [1:0] lock_ff;
  logic [2:0] lat_ff;
  logic       sel, rd_pin, rd_go, mrs_go, bst_go, act_pin;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  assign sel     = !chip_select_n && gate_q_ff && !static_op_select;
  assign rd_pin  = sel && clk_gate_in && row_strobe_n && !col_strobe_n && mode_write_n;
  assign rd_go   = rd_pin && lock_ff == 2'h0;
  assign mrs_go  = sel && lock_ff == 2'h0 && !row_strobe_n && !col_strobe_n && !mode_write_n;
  assign bst_go  = sel && lock_ff == 2'h0 && col_strobe_n && !mode_write_n;
  assign act_pin = !chip_select_n && !row_strobe_n && col_strobe_n && mode_write_n;

  // Previous clock enable and mode-set lockout
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_q_ff <= 1'b1;
      lock_ff   <= 2'h0;
    end else begin
      gate_q_ff <= clk_gate_in;
      lock_ff   <= mrs_go ? MRS_LOCK_CYC : lock_ff - (lock_ff != 2'h0 ? 2'h1 : 2'h0);
    end
  end

  // Shadow of the latency field
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lat_ff <= RST_LAT;
    end else if (mrs_go && addr_in[5:3] >= LAT_CODE_4 && addr_in[5:3] <= LAT_CODE_6) begin
      lat_ff <= addr_in[5:3] + LAT_CODE_OFS;
    end
  end

  a_mask_floats:
  assert property (output_mask |-> !dq_oe) else $error("data driven while masked");
  a_read_lat5:
  assert property (rd_go && lat_ff == 3'h5 ##1 clk_gate_in [*3] |=> array_rd)
    else $error("array read late for latency five");
  a_read_lat4:
  assert property (rd_go && lat_ff == 3'h4 ##1 clk_gate_in [*2] |=> array_rd)
    else $error("array read late for latency four");
  a_width_pick:
  assert property (rd_go && lat_ff == 3'h5 ##1 clk_gate_in [*3]
    |=> array_wide == $past(width_select, 4)) else $error("width not taken from read");
  a_mrs_lockout:
  assert property (mrs_go ##[1:3] rd_pin |=> !array_rd [*7])
    else $error("read accepted during lockout");
  a_stop_halts:
  assert property (bst_go && lat_ff == 3'h5 ##1 (chip_select_n && clk_gate_in) [*3]
    |=> !array_rd [*3]) else $error("burst runs on after stop");
  a_freeze_dout:
  assert property (!clk_gate_in |-> ##2 $stable(dq_out)) else $error("data moved in suspend");
  a_oe_follows:
  assert property ($rose(dq_oe) && $stable(output_mask) |-> $past(array_rd))
    else $error("data valid without array read");
  a_row_held:
  assert property (!act_pin |=> $stable(array_row)) else $error("row changed without activate");
endmodule : sotp_read_ctrl_properties

// File: verif/sotp_ctl_model.sv
`timescale 1ns/100ps
module sotp_ctl_model (
  input  wire logic                   clk_sys,
  output sotp_pkg::sotp_pins_t        pins,
  output logic [sotp_pkg::ADDR_W-1:0] addr,
  output logic                        wide
);
  import sotp_pkg::*;
  initial begin
    pins = 4'hF;
    addr = '0;
    wide = 1'b0;
  end
  // One command cycle, then chip select high for gap+1 cycles
  task automatic issue(input logic [3:0] p, input logic [ADDR_W-1:0] a, input logic w,
                       input int gap);
    pins <= p;
    addr <= a;
    wide <= w;
    @(posedge clk_sys);
    pins <= 4'hF;
    addr <= ~a;
    repeat (gap + 1) @(posedge clk_sys);
  endtask : issue
  task automatic mrs(input logic [5:0] code, input int gap);
    issue(4'h0, {7'h00, code}, 1'b0, gap);
  endtask : mrs
endmodule : sotp_ctl_model

// File: verif/sync_otp_read_control_test.sv
`timescale 1ns/100ps
module sync_otp_read_control_test;
  import sotp_pkg::*;
  logic              clk_sys, rstn, hsel, hwrite, hready, hreadyout;
  logic              clk_gate_in, output_mask, dq_oe, width_select, ilv_v, bl8_v;
  logic              static_op_select, hresp;
  logic [1:0]        htrans;
  logic [31:0]       haddr, hwdata, hrdata, array_rdata, dq_out, r, m_q;
  logic [ROW_W-1:0]  array_row, row_v;
  logic [COL_W-1:0]  array_col;
  logic [ADDR_W-1:0] addr_in;
  logic [32:0]       e_q;
  logic [32:0]       exq[$];
  sotp_pins_t        pins;
  int                n_mismatch, samples_checked;

  assign hready      = hreadyout;
  assign array_rdata = {array_row[6:0], array_col, array_row[6:0], array_col};

  sotp_ctl_model u_ctl (.clk_sys, .pins, .addr(addr_in), .wide(width_select));
  sotp_read_ctrl dut (
    .clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .clk_gate_in, .chip_select_n(pins.cs_n),
    .row_strobe_n(pins.ras_n), .col_strobe_n(pins.cas_n), .mode_write_n(pins.mw_n),
    .width_select, .output_mask, .static_op_select, .addr_in, .array_rd(),
    .array_row, .array_col, .array_wide(), .array_rdata, .dq_out, .dq_oe);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] beat(input logic [8:0] c, input int k);
    logic [2:0] m;
    logic [2:0] lo;
    logic [8:0] b;
    m  = bl8_v ? 3'h7 : 3'h3;
    lo = ilv_v ? c[2:0] ^ 3'(k) : c[2:0] + 3'(k);
    b  = {c[8:3], (c[2:0] & ~m) | (lo & m)};
    return {row_v[6:0], b, row_v[6:0], b};
  endfunction : beat

  task automatic hwait;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (hready === 1'b1) return;
    end
    chk("hready_wait", 32'h0000_0001, 32'h0000_0000);
    print_verdict();
  endtask : hwait

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask : ahb

  task automatic rd(input logic [8:0] c, input logic w, input int n, input int gap);
    for (int k = 0; k < n; k++) exq.push_back({w, beat(c, k)});
    u_ctl.issue(4'h5, {4'h0, c}, w, gap);
  endtask : rd

  task automatic drain;
    for (int i = 0; i < 80 && exq.size() != 0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk("beats_left", 32'h0000_0000, 32'(exq.size()));
    if (exq.size() != 0) begin
      print_verdict();
    end
  endtask : drain

  // Each valid beat takes the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (dq_oe === 1'b1) begin
      e_q = exq.size() != 0 ? exq.pop_front() : {1'b1, ~dq_out};
      m_q = e_q[32] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      chk("dq_out", e_q[31:0] & m_q, dq_out & m_q);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    chk("timeout", 32'h0000_0001, 32'h0000_0000);
    print_verdict();
  end

  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    static_op_select = 1'b0;
    {clk_gate_in, output_mask, row_v, ilv_v, bl8_v} = {1'b1, 16'h0000};
    n_mismatch      = 0;
    samples_checked = 0;
    void'($urandom(32'h6b05_4379));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    ahb(1'b0, REG_STAT_ADDR, 32'h0000_0000);
    chk("status_reset", 32'h0000_0050, r);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, r);
    ahb(1'b1, REG_CTRL_ADDR, 32'h0000_0000);
    u_ctl.issue(4'h3, 13'h1FFF, 1'b0, 0);
    ahb(1'b0, REG_STAT_ADDR, 32'h0000_0000);
    chk("row_while_off", 32'h0000_0000, r & 32'h1FFF_0000);
    ahb(1'b1, REG_CTRL_ADDR, 32'h0000_0001);
    ahb(1'b0, REG_CTRL_ADDR, 32'h0000_0000);
    chk("ctrl", 32'h0000_0001, r);
    row_v = 13'($urandom);
    u_ctl.issue(4'h3, row_v, 1'b0, 0);
    for (int w = 1; w >= 0; w--) begin
      rd(9'($urandom), 1'(w), 4, 0);
      drain();
    end
    // Masked read and static-op read never show data
    output_mask <= 1'b1;
    u_ctl.issue(4'h5, 13'($urandom), 1'b1, 12);
    {output_mask, static_op_select} <= 2'b01;
    u_ctl.issue(4'h5, 13'($urandom), 1'b1, 12);
    static_op_select <= 1'b0;
    drain();
    for (int i = 0; i < 3; i++) begin
      ilv_v = (i != 0);
      bl8_v = (i != 1);
      u_ctl.mrs({3'h3 + 3'(i), ilv_v, (bl8_v ? 2'h2 : 2'h1)}, 3);
      rd(9'($urandom), 1'($urandom), bl8_v ? 8 : 4, 0);
      drain();
    end
    {ilv_v, bl8_v} = 2'h0;
    u_ctl.mrs(6'h21, 3);
    u_ctl.mrs(6'h21, 0);
    u_ctl.issue(4'h5, 13'($urandom), 1'b1, 10);
    drain();
    for (int i = 0; i < 2; i++) begin
      rd(9'($urandom), 1'b1, 2, 0);
      u_ctl.issue(i == 0 ? 4'h6 : 4'h2, 13'h0000, 1'b0, 0);
      drain();
    end
    u_ctl.issue(4'h6, 13'h0000, 1'b0, 0);
    drain();
    rd(9'($urandom), 1'b1, 4, 0);
    clk_gate_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_gate_in <= 1'b1;
    drain();
    clk_gate_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, REG_STAT_ADDR, 32'h0000_0000);
    chk("power_down", 32'h0000_0003, r & 32'h0000_0003);
    clk_gate_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ahb(1'b0, REG_STAT_ADDR, 32'h0000_0000);
    chk("standby_row", {3'h0, row_v, 16'h0000}, r & 32'h1FFF_0003);
    rd(9'($urandom), 1'b0, 4, 0);
    drain();
    print_verdict();
  end
endmodule : sync_otp_read_control_test

bind sotp_read_ctrl sotp_read_ctrl_properties u_props (
  .clk_sys, .rstn, .clk_gate_in, .chip_select_n, .row_strobe_n, .col_strobe_n, .mode_write_n,
  .width_select, .output_mask, .static_op_select, .addr_in, .array_rd, .array_row,
  .array_wide, .dq_out, .dq_oe);
